// ===== bench/sd_link_asserts.sv
`timescale 1ns/1ps
module sd_link_asserts (
    // host clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // link wires
    input wire logic sample_clock_in,
    input wire logic bitstream_out,
    // decimator outputs and its word_ready input
    input wire logic [sd_pkg::WORD_W-1:0] latest_code,
    input wire logic latest_strobe,
    input wire logic word_valid,
    input wire logic word_ready,
    input wire logic [sd_pkg::WORD_W-1:0] word_data,
    input wire logic word_lost
);
    import sd_pkg::*;
    logic [10:0] gap_d;
    logic [10:0] gap_q;
    logic seen_d;
    logic seen_q;
    default clocking dc @(posedge clk); endclocking
    default disable iff (sys_rst);
    // cycles since the last word update
    always_comb begin
        gap_d = latest_strobe ? 11'h000 : gap_q + 11'h001;
        seen_d = seen_q | latest_strobe;
        if (sys_rst) begin
            gap_d = 11'h000;
            seen_d = 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        gap_q <= gap_d;
        seen_q <= seen_d;
    end
    // link clock phases
    sequence sck_high2;
        sample_clock_in [*2];
    endsequence
    sequence sck_low2;
        !sample_clock_in [*2];
    endsequence
    a_link_clock_div: assert property ($rose(sample_clock_in) |-> sck_high2 ##1 sck_low2 ##1 sample_clock_in)
        else $error("link clock not a quarter of clk");
    a_bit_on_rise: assert property ($changed(bitstream_out) |-> $rose(sample_clock_in))
        else $error("bit changed away from a link rising edge");
    a_word_period: assert property (latest_strobe && seen_q |-> gap_q == 11'h3ff)
        else $error("word spacing not 1024 cycles");
    a_code_held: assert property (!latest_strobe |-> $stable(latest_code))
        else $error("code changed without update pulse");
    a_lost_with_update: assert property (word_lost |-> latest_strobe)
        else $error("word loss outside an update");
    a_push_shows: assert property (latest_strobe && !word_lost |-> word_valid)
        else $error("pushed word not visible");
    a_reset_midscale: assert property ($fell(sys_rst) |-> latest_code == CODE_MIDSCALE && !word_valid)
        else $error("state not cleared by reset");
    a_head_held: assert property (word_valid && !word_ready |=> word_valid && $stable(word_data))
        else $error("buffer head moved while stalled");
endmodule

// ===== bench/sigma_delta_bitstream_readout_tb.sv
`timescale 1ns/1ps
module sigma_delta_bitstream_readout_tb;
    import sd_pkg::*;
    logic clk, sys_rst, dev_rst, clk_en, word_ready;
    logic signed [ANA_W-1:0] ana_pos, ana_neg;
    logic [WORD_W-1:0] latest_code, word_data;
    logic latest_strobe, word_valid, word_lost;
    int fails, n_checks, nbits, ones;
    sd_link_if sd_link_if_inst ();
    sd_modulator sd_modulator_inst (.link(sd_link_if_inst), .sys_rst(dev_rst), .clk_en(clk_en),
        .analog_input_pos(ana_pos), .analog_input_neg(ana_neg));
    sd_decimator sd_decimator_inst (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .link(sd_link_if_inst),
        .latest_code(latest_code), .latest_strobe(latest_strobe), .word_valid(word_valid),
        .word_ready(word_ready), .word_data(word_data), .word_lost(word_lost));
    sd_link_asserts sd_link_asserts_inst (.clk(clk), .sys_rst(sys_rst),
        .sample_clock_in(sd_link_if_inst.sample_clock_in), .bitstream_out(sd_link_if_inst.bitstream_out),
        .latest_code(latest_code), .latest_strobe(latest_strobe), .word_valid(word_valid),
        .word_ready(word_ready), .word_data(word_data), .word_lost(word_lost));
    // clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ones count, sampled mid-period away from the launch edge
    always @(negedge sd_link_if_inst.sample_clock_in) begin
        nbits = nbits + 1;
        ones = ones + int'(sd_link_if_inst.bitstream_out === 1'b1);
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t mismatch got %0d exp %0d", $time, got, exp);
        end
    endtask
    function automatic logic near(input logic [31:0] got, input int exp, input int tol);
        int d;
        if ((^got) === 1'bx) return 1'b0;
        d = int'(got) - exp;
        return d <= tol && d >= -tol;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wait_strobe();
        int k;
        k = 0;
        tick(1);
        while (latest_strobe !== 1'b1 && k < 1100) begin
            tick(1);
            k++;
        end
        check(latest_strobe, 1'b1);
    endtask
    // steady input: density of ones and settled code
    task automatic level_case(input int pos, input int neg, input int code, input int ctol, input int dens);
        int k;
        ana_pos = pos[ANA_W-1:0];
        ana_neg = neg[ANA_W-1:0];
        // six words: the step and the filter pipeline both leave the window
        repeat (6) wait_strobe();
        nbits = 0;
        ones = 0;
        k = 0;
        while (nbits < 256 && k < 1100) begin
            tick(1);
            k++;
        end
        check(near(ones, dens, 3), 1'b1);
        wait_strobe();
        check(near(latest_code, code, ctol), 1'b1);
    endtask
    // fill the buffer until a word is lost, then drain back to back
    task automatic fifo_fill_drain();
        logic [WORD_W-1:0] q[$];
        wait_strobe();
        tick(2);
        word_ready = 1'b0;
        repeat (FIFO_DEPTH) begin
            wait_strobe();
            q.push_back(latest_code);
            check(word_lost, 1'b0);
        end
        wait_strobe();
        check(word_lost, 1'b1);
        word_ready = 1'b1;
        repeat (FIFO_DEPTH) begin
            check(word_valid, 1'b1);
            check(word_data, q.pop_front());
            tick(1);
        end
        check(word_valid, 1'b0);
    endtask
    // reset in mid-run with a word buffered clears buffer and filter state
    task automatic reset_mid();
        word_ready = 1'b0;
        wait_strobe();
        check(word_valid, 1'b1);
        tick(100);
        sys_rst = 1'b1;
        tick(2);
        check(latest_code, CODE_MIDSCALE);
        check(word_valid, 1'b0);
        check(sd_link_if_inst.sample_clock_in, 1'b1);
        sys_rst = 1'b0;
        word_ready = 1'b1;
        // first word after reset comes from cleared differentiators
        wait_strobe();
        check(latest_code, CODE_MIDSCALE);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // watchdog
    initial begin
        tick(90000);
        fails++;
        $display("ERROR %0t watchdog expired", $time);
        final_report();
    end
    // main sequence
    initial begin
        sys_rst = 1'b1;
        dev_rst = 1'b1;
        clk_en = 1'b1;
        word_ready = 1'b1;
        ana_pos = 16'h0000;
        ana_neg = 16'h0000;
        fails = 0;
        n_checks = 0;
        nbits = 0;
        ones = 0;
        tick(12);
        sys_rst = 1'b0;
        check(latest_code, CODE_MIDSCALE);
        tick(16);
        dev_rst = 1'b0;
        level_case(0, 0, 32768, 24, 128);
        level_case(20000, 0, 53248, 24, 208);
        level_case(-10000, 10000, 12288, 24, 48);
        level_case(25000, 0, 58366, 24, 228);
        level_case(-25000, 0, 7169, 24, 28);
        level_case(32000, 0, 65535, 0, 256);
        fifo_fill_drain();
        reset_mid();
        final_report();
    end
endmodule

// ===== design/sd_decimator.sv
`timescale 1ns/1ps
module sd_word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
    localparam logic [AW:0] CNT_NONE = '0;
    localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
    localparam logic [AW-1:0] PTR_NONE = '0;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    // pointer wrap used by both pointers
    function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
        ptr_next = (p == PTR_LAST) ? PTR_NONE : p + 1'b1;
    endfunction

    assign in_ready = (cnt_q != CNT_FULL);
    assign out_valid = (cnt_q != CNT_NONE);
    assign out_data = mem_q[rd_q];

    // next pointers, count and storage
    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        for (int i = 0; i < DEPTH; i++) begin
            mem_d[i] = mem_q[i];
        end
        if (clk_en) begin
            if (push) begin
                mem_d[wr_q] = in_data;
                wr_d = ptr_next(wr_q);
            end
            if (pop) begin
                rd_d = ptr_next(rd_q);
            end
            if (push && !pop) begin
                cnt_d = cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_d = cnt_q - 1'b1;
            end
        end
        if (sys_rst) begin
            wr_d = PTR_NONE;
            rd_d = PTR_NONE;
            cnt_d = CNT_NONE;
        end
    end

    always_ff @(posedge clk) begin
        wr_q <= wr_d;
        rd_q <= rd_d;
        cnt_q <= cnt_d;
        for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= mem_d[i];
        end
    end
endmodule

module sd_decimator (
    // clock, reset, enable
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // link side
    sd_link_if.host link,
    // latest filtered code, held between updates
    output logic [sd_pkg::WORD_W-1:0] latest_code,
    output logic latest_strobe,
    // buffered word stream
    output logic word_valid,
    input wire logic word_ready,
    output logic [sd_pkg::WORD_W-1:0] word_data,
    // word dropped because the buffer was full
    output logic word_lost
);
    import sd_pkg::*;

    logic [PH_W-1:0] phase_q, phase_d;
    logic link_clk_q, link_clk_d;
    logic bit_s1_q, bit_s1_d, bit_s2_q, bit_s2_d;
    logic capture;
    logic [CNT_W-1:0] count_q, count_d;
    logic [ACC_W-1:0] integ_q [ORDER];
    logic [ACC_W-1:0] integ_d [ORDER];
    logic [ACC_W-1:0] delay_q [ORDER];
    logic [ACC_W-1:0] delay_d [ORDER];
    logic [ACC_W-1:0] diff_q [ORDER];
    logic [ACC_W-1:0] diff_d [ORDER];
    logic [ACC_W-1:0] sample;
    logic [ACC_W-1:0] shifted;
    logic [WORD_W-1:0] code_q, code_d;
    logic strobe_q, strobe_d;
    logic lost_q, lost_d;
    logic word_end;
    logic fifo_in_ready;

    // link clock divider; capture just before each rising edge
    always_comb begin
        phase_d = phase_q;
        link_clk_d = link_clk_q;
        bit_s1_d = link.bitstream_out;
        bit_s2_d = bit_s1_q;
        capture = clk_en && (phase_q == PH_CAPTURE);
        if (clk_en) begin
            phase_d = phase_q + PH_STEP;
            if (phase_d == PH_RISE) begin
                link_clk_d = 1'b1;
            end else if (phase_d == PH_FALL) begin
                link_clk_d = 1'b0;
            end
        end
        if (sys_rst) begin
            phase_d = PH_RISE;
            link_clk_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        phase_q <= phase_d;
        link_clk_q <= link_clk_d;
        bit_s1_q <= bit_s1_d;
        bit_s2_q <= bit_s2_d;
    end

    assign link.sample_clock_in = link_clk_q;

    // sinc3: integrators per bit, differentiators per word
    always_comb begin
        sample = bit_s2_q ? ACC_PLUS_ONE : ACC_MINUS_ONE;
        word_end = capture && (count_q == CNT_LAST);
        count_d = count_q;
        for (int i = 0; i < ORDER; i++) begin
            integ_d[i] = integ_q[i];
            delay_d[i] = delay_q[i];
            diff_d[i] = diff_q[i];
        end
        if (capture) begin
            count_d = count_q + 1'b1;
            integ_d[0] = integ_q[0] + sample;
            for (int i = 1; i < ORDER; i++) begin
                integ_d[i] = integ_q[i] + integ_q[i-1];
            end
        end
        if (word_end) begin
            diff_d[0] = integ_q[ORDER-1] - delay_q[0];
            delay_d[0] = integ_q[ORDER-1];
            for (int i = 1; i < ORDER; i++) begin
                diff_d[i] = diff_q[i-1] - delay_q[i];
                delay_d[i] = diff_q[i-1];
            end
        end
        if (sys_rst) begin
            count_d = CNT_ZERO;
            for (int i = 0; i < ORDER; i++) begin
                integ_d[i] = ACC_ZERO;
                delay_d[i] = ACC_ZERO;
                diff_d[i] = ACC_ZERO;
            end
        end
    end

    always_ff @(posedge clk) begin
        count_q <= count_d;
        for (int i = 0; i < ORDER; i++) begin
            integ_q[i] <= integ_d[i];
            delay_q[i] <= delay_d[i];
            diff_q[i] <= diff_d[i];
        end
    end

    // offset-binary code, saturated at full ones
    always_comb begin
        shifted = diff_q[ORDER-1] + ACC_OFFSET;
        code_d = code_q;
        strobe_d = 1'b0;
        lost_d = 1'b0;
        if (word_end) begin
            // the last differentiator settles one word later
            if (shifted[ACC_W-1]) begin
                code_d = CODE_MAX;
            end else begin
                code_d = shifted[OUT_LSB +: WORD_W];
            end
            strobe_d = 1'b1;
            lost_d = !fifo_in_ready;
        end
        if (sys_rst) begin
            code_d = CODE_MIDSCALE;
            strobe_d = 1'b0;
            lost_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        code_q <= code_d;
        strobe_q <= strobe_d;
        lost_q <= lost_d;
    end

    assign latest_code = code_q;
    assign latest_strobe = strobe_q;
    assign word_lost = lost_q;

    // buffered copy of each new code while the buffer has room
    sd_word_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) sd_word_fifo_inst (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .in_valid(word_end),
        .in_ready(fifo_in_ready),
        .in_data(code_d),
        .out_valid(word_valid),
        .out_ready(word_ready),
        .out_data(word_data)
    );
endmodule

// ===== design/sd_link_if.sv
`timescale 1ns/1ps
interface sd_link_if;
    logic sample_clock_in;
    logic bitstream_out;
    modport device (input sample_clock_in, output bitstream_out);
    modport host (output sample_clock_in, input bitstream_out);
endinterface

// ===== design/sd_modulator.sv
`timescale 1ns/1ps
module sd_modulator (
    // link side
    sd_link_if.device link,
    // user side, host-domain levels
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic signed [sd_pkg::ANA_W-1:0] analog_input_pos,
    input wire logic signed [sd_pkg::ANA_W-1:0] analog_input_neg
);
    import sd_pkg::*;

    logic [1:0] rst_sync_q, rst_sync_d;
    logic [1:0] en_sync_q, en_sync_d;
    logic signed [ANA_W-1:0] pos_s1_q, pos_s1_d, pos_s2_q, pos_s2_d;
    logic signed [ANA_W-1:0] neg_s1_q, neg_s1_d, neg_s2_q, neg_s2_d;
    logic signed [MOD_W-1:0] int1_q, int1_d, int2_q, int2_d;
    logic signed [MOD_W+1:0] sum1, sum2;
    localparam logic signed [MOD_W-1:0] MOD_MAX = {1'b0, {(MOD_W-1){1'b1}}};
    localparam logic signed [MOD_W-1:0] MOD_MIN = {1'b1, {(MOD_W-1){1'b0}}};
    localparam logic signed [MOD_W+1:0] SUM_MAX = (MOD_W+2)'(MOD_MAX);
    localparam logic signed [MOD_W+1:0] SUM_MIN = (MOD_W+2)'(MOD_MIN);

    // integrator update clipped at the range ends; a wrap would flip the loop at full scale
    function automatic logic signed [MOD_W-1:0] clip(input logic signed [MOD_W+1:0] v);
        if (v > SUM_MAX) begin
            clip = MOD_MAX;
        end else if (v < SUM_MIN) begin
            clip = MOD_MIN;
        end else begin
            clip = v[MOD_W-1:0];
        end
    endfunction
    logic bit_q, bit_d;
    logic signed [ANA_W:0] diff_in, clamped, feedback;

    // two-flop crossing into the link domain; inputs are slow levels
    always_comb begin
        rst_sync_d = {rst_sync_q[0], sys_rst};
        en_sync_d = {en_sync_q[0], clk_en};
        pos_s1_d = analog_input_pos;
        pos_s2_d = pos_s1_q;
        neg_s1_d = analog_input_neg;
        neg_s2_d = neg_s1_q;
    end

    always_ff @(posedge link.sample_clock_in) begin
        rst_sync_q <= rst_sync_d;
        en_sync_q <= en_sync_d;
        pos_s1_q <= pos_s1_d;
        pos_s2_q <= pos_s2_d;
        neg_s1_q <= neg_s1_d;
        neg_s2_q <= neg_s2_d;
    end

    // second-order loop, feedback at plus/minus full scale
    always_comb begin
        diff_in = 17'(pos_s2_q) - 17'(neg_s2_q);
        if (diff_in > ANA_FULL_SCALE) begin
            clamped = ANA_FULL_SCALE;
        end else if (diff_in < -ANA_FULL_SCALE) begin
            clamped = -ANA_FULL_SCALE;
        end else begin
            clamped = diff_in;
        end
        feedback = bit_q ? ANA_FULL_SCALE : -ANA_FULL_SCALE;
        sum1 = (MOD_W+2)'(int1_q) + (MOD_W+2)'(clamped) - (MOD_W+2)'(feedback);
        int1_d = clip(sum1);
        sum2 = (MOD_W+2)'(int2_q) + (MOD_W+2)'(int1_d) - (MOD_W+2)'(feedback);
        int2_d = clip(sum2);
        bit_d = (int2_d >= MOD_ZERO);
        if (rst_sync_q[1]) begin
            int1_d = MOD_ZERO;
            int2_d = MOD_ZERO;
            bit_d = 1'b0;
        end else if (!en_sync_q[1]) begin
            int1_d = int1_q;
            int2_d = int2_q;
            bit_d = bit_q;
        end
    end

    // one bit launched per rising edge
    always_ff @(posedge link.sample_clock_in) begin
        int1_q <= int1_d;
        int2_q <= int2_d;
        bit_q <= bit_d;
    end

    assign link.bitstream_out = bit_q;
endmodule

// ===== design/sd_pkg.sv
// Behaviour
// - external sample clock drives conversion and framing
// - sample clock at most 20 MHz, one bit each
// - ones density proportional to differential input
// - zero input gives half ones
// - plus/minus 200 mV give 81.25/18.75 percent
// - plus/minus 250 mV give 89.06/10.94 percent
// - 320 mV input gives all ones
// - receiver filters and decimates with sinc3
// - ratio 256 gives one 16-bit word
// - minus/plus 250 mV map to 7169/58366
// - zero input maps to midscale 32768
// - launch on rising edge, capture next rising
// - three integrators, then three differentiators
package sd_pkg;
    // decimation and word format
    localparam int DECIM_RATIO = 256;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_LAST = 8'hff;
    localparam int WORD_W = 16;
    localparam int ORDER = 3;
    // accumulators hold 2 * 256^3 without wrap
    localparam int ACC_W = 26;
    localparam logic [ACC_W-1:0] ACC_ZERO = 26'h0000000;
    localparam logic [ACC_W-1:0] ACC_PLUS_ONE = 26'h0000001;
    localparam logic [ACC_W-1:0] ACC_MINUS_ONE = 26'h3ffffff;
    localparam logic [ACC_W-1:0] ACC_OFFSET = 26'h1000000;
    localparam int OUT_LSB = 9;
    localparam logic [WORD_W-1:0] CODE_ZERO = 16'h0000;
    localparam logic [WORD_W-1:0] CODE_MAX = 16'hffff;
    // ideal reference codes of the transfer curve
    localparam logic [WORD_W-1:0] CODE_NEG_250MV = 16'h1c01;
    localparam logic [WORD_W-1:0] CODE_MIDSCALE = 16'h8000;
    localparam logic [WORD_W-1:0] CODE_POS_250MV = 16'he3fe;
    // analog inputs in units of 10 uV, signed
    localparam int ANA_W = 16;
    localparam logic signed [ANA_W:0] ANA_FULL_SCALE = 17'sh07d00;
    localparam int MOD_W = 24;
    localparam logic signed [MOD_W-1:0] MOD_ZERO = 24'sh000000;
    // clocks: host clk 40 MHz, link clock made by divider
    localparam int CLK_PERIOD_NS = 25;
    localparam int LINK_MAX_MHZ = 20;
    localparam int LINK_DIV = 4;
    localparam int LINK_PERIOD_NS = CLK_PERIOD_NS * LINK_DIV;
    localparam int LINK_MIN_PERIOD_NS = 1000 / LINK_MAX_MHZ;
    localparam int PH_W = 2;
    localparam logic [PH_W-1:0] PH_RISE = 2'h0;
    localparam logic [PH_W-1:0] PH_FALL = 2'h2;
    localparam logic [PH_W-1:0] PH_CAPTURE = 2'h3;
    localparam logic [PH_W-1:0] PH_STEP = 2'h1;
    // output word buffer
    localparam int FIFO_DEPTH = 8;
endpackage
